//--- core/usb_host_list_control_cmd.sv
// operating mode and command registers with list gating for the host core
// assumes the list walker and bus master run on i_sys_clk, events one cycle
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/100ps

// Operation
// - iso descriptors skipped while iso enable clear
// - iso enable honoured within current frame
// - periodic enable clear stops next frame
// - periodic enable set starts next frame
// - serve ratio plus one control per bulk
// - overrun count bumps on every overrun except one in the soft reset end cycle
// - ownership request settable, raises no interrupt
// - zero bulk pointer needs bulk filled
// - bulk filled cleared when bulk starts
// - zero control head needs control filled
// - control filled cleared when control starts
// - writing one starts soft reset, zero nothing
// - soft reset never drives usb reset
// - soft reset leaves functional state suspend
module usb_host_list_control_cmd #(
    parameter int PTR_W             = usb_hc_list_pkg::PTR_W,
    parameter int SOFT_RESET_CYCLES = usb_hc_list_pkg::SOFT_RESET_CYCLES
) (
    // clock and reset
    input  wire logic                              i_sys_clk,
    input  wire logic                              i_rst,
    input  wire logic                              i_clk_en,
    // register port
    input  wire logic [usb_hc_list_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [usb_hc_list_pkg::DATA_W-1:0] i_wr_data,
    input  wire logic                              i_wr_en,
    input  wire logic                              i_rd_en,
    output logic [usb_hc_list_pkg::DATA_W-1:0]     o_rd_data,
    // list walker
    input  wire usb_hc_list_pkg::sched_evt_t       i_evt,
    input  wire logic [PTR_W-1:0]                  i_bulk_current_ptr,
    input  wire logic [PTR_W-1:0]                  i_control_head_ptr,
    output logic                                   o_periodic_active,
    output logic                                   o_iso_valid,
    output logic                                   o_iso_accept,
    output logic                                   o_ctrl_grant,
    output logic                                   o_bulk_grant,
    output logic                                   o_pick_bulk,
    // core state
    output logic                                   o_soft_reset_busy,
    output logic                                   o_usb_reset_drive,
    output logic                                   o_irq
);
    import usb_hc_list_pkg::*;

    localparam int CNT_W = $clog2(SOFT_RESET_CYCLES + 1);
    localparam logic [CNT_W-1:0] SR_LAST = CNT_W'(SOFT_RESET_CYCLES - 1);

    op_mode_t             op;
    sr_state_t            sr_state;
    logic [CNT_W-1:0]     sr_cnt;
    logic                 control_list_filled;
    logic                 bulk_list_filled;
    logic                 ownership_request;
    logic [1:0]           soc;
    logic [IRQ_W-1:0]     irq_status;
    logic [IRQ_W-1:0]     irq_mask;
    logic [IRQ_W-1:0]     next_irq_status;
    logic                 wr_op;
    logic                 wr_cmd;
    logic                 wr_stat;
    logic                 wr_mask;
    logic                 sr_done;
    logic                 next_ctrl_grant;
    logic                 next_bulk_grant;

    // list may start if pointer live or list marked filled
    function automatic logic start_ok(input logic          req,
                                      input logic          enable,
                                      input logic [PTR_W-1:0] ptr,
                                      input logic          filled);
        start_ok = req && enable && ((ptr != '0) || filled);
    endfunction : start_ok

    // writes other than the command register are dropped while a soft reset runs
    assign wr_op   = i_wr_en && (i_addr == OFF_OP_MODE) &&
                     (sr_state == SR_IDLE);
    assign wr_cmd  = i_wr_en && (i_addr == OFF_CMD_STATE);
    assign wr_stat = i_wr_en && (i_addr == OFF_IRQ_STATUS) &&
                     (sr_state == SR_IDLE);
    assign wr_mask = i_wr_en && (i_addr == OFF_IRQ_MASK) &&
                     (sr_state == SR_IDLE);
    assign sr_done = i_clk_en && (sr_state == SR_BUSY) && (sr_cnt == SR_LAST);

    // bulk and control start gates
    // no start while soft reset runs; its end still clears any filled bit unserved
    assign next_bulk_grant = (sr_state == SR_IDLE) &&
                             start_ok(i_evt.bulk_start_req,
                                      op.bulk_list_enable,
                                      i_bulk_current_ptr,
                                      bulk_list_filled);
    assign next_ctrl_grant = (sr_state == SR_IDLE) &&
                             start_ok(i_evt.ctrl_start_req,
                                      op.control_list_enable,
                                      i_control_head_ptr,
                                      control_list_filled);

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sr_state <= SR_IDLE;
            sr_cnt   <= '0;
        end else if (i_clk_en) begin
            case (sr_state)
                SR_IDLE: begin
                    sr_cnt <= '0;
                    if (wr_cmd && i_wr_data[CMD_RESET_BIT]) begin
                        sr_state <= SR_BUSY;
                    end
                end
                SR_BUSY: begin
                    if (sr_cnt == SR_LAST) begin
                        sr_state <= SR_IDLE;
                        sr_cnt   <= '0;
                    end else begin
                        sr_cnt <= sr_cnt + CNT_W'(1);
                    end
                end
                default: begin
                    sr_state <= SR_IDLE;
                    sr_cnt   <= '0;
                end
            endcase
        end
    end

    // operating mode register
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            op <= op_mode_t'(OP_MODE_RESET);
        end else if (i_clk_en) begin
            if (sr_done) begin
                op                  <= op_mode_t'(OP_MODE_RESET);
                op.functional_state <= FS_SUSPEND;
            end else if (wr_op) begin
                op <= op_mode_t'(i_wr_data[7:0]);
            end
        end
    end

    // command flags; a driver set beats a same-cycle start clear, not the soft reset end clear
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            control_list_filled <= 1'b0;
            bulk_list_filled    <= 1'b0;
            ownership_request   <= 1'b0;
        end else if (i_clk_en) begin
            if (sr_done) begin
                control_list_filled <= 1'b0;
                bulk_list_filled    <= 1'b0;
                ownership_request   <= 1'b0;
            end else begin
                if (wr_cmd && i_wr_data[CMD_CLF_BIT]) begin
                    control_list_filled <= 1'b1;
                end else if (next_ctrl_grant) begin
                    control_list_filled <= 1'b0;
                end
                if (wr_cmd && i_wr_data[CMD_BLF_BIT]) begin
                    bulk_list_filled <= 1'b1;
                end else if (next_bulk_grant) begin
                    bulk_list_filled <= 1'b0;
                end
                if (wr_cmd && i_wr_data[CMD_OWN_BIT]) begin
                    ownership_request <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            soc <= SOC_RESET;
        end else if (i_clk_en) begin
            if (sr_done) begin
                soc <= SOC_RESET;
            end else if (i_evt.overrun) begin
                soc <= soc + 2'h1;
            end
        end
    end

    // sticky events; set wins over write-one-to-clear
    always_comb begin
        next_irq_status = irq_status;
        if (wr_stat) begin
            next_irq_status = irq_status & ~i_wr_data[IRQ_W-1:0];
        end
        if (sr_done) begin
            next_irq_status = IRQ_RESET;
            next_irq_status[IRQ_RSTDONE_BIT] = 1'b1;
        end
        if (i_evt.overrun) begin
            next_irq_status[IRQ_OVERRUN_BIT] = 1'b1;
        end
    end

    // interrupt status, mask and line; line lags status by one cycle
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_status <= IRQ_RESET;
            irq_mask   <= IRQ_RESET;
            o_irq      <= 1'b0;
        end else if (i_clk_en) begin
            irq_status <= next_irq_status;
            if (wr_mask) begin
                irq_mask <= i_wr_data[IRQ_W-1:0];
            end
            o_irq <= |(irq_status & irq_mask);
        end
    end

    // periodic gate and iso verdicts
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_periodic_active <= 1'b0;
            o_iso_valid       <= 1'b0;
            o_iso_accept      <= 1'b0;
        end else if (i_clk_en) begin
            if (sr_done) begin
                o_periodic_active <= 1'b0;
            end else if (i_evt.frame_start) begin
                o_periodic_active <= op.periodic_list_enable;
            end
            o_iso_valid  <= i_evt.iso_ed_seen;
            o_iso_accept <= i_evt.iso_ed_seen && op.iso_enable &&
                            o_periodic_active;
        end
    end

    // grants and core state lines
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ctrl_grant      <= 1'b0;
            o_bulk_grant      <= 1'b0;
            o_soft_reset_busy <= 1'b0;
            o_usb_reset_drive <= 1'b1;
        end else if (i_clk_en) begin
            o_ctrl_grant      <= next_ctrl_grant;
            o_bulk_grant      <= next_bulk_grant;
            o_soft_reset_busy <= (sr_state == SR_BUSY) && !sr_done;
            // only the reset state signals usb reset
            o_usb_reset_drive <= (op.functional_state == FS_RESET);
        end
    end

    // read data for one cycle only; unmapped reads zero
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rd_data <= '0;
        end else if (i_clk_en) begin
            o_rd_data <= '0;
            if (i_rd_en) begin
                case (i_addr)
                    OFF_OP_MODE:    o_rd_data <= {24'h0, op};
                    OFF_CMD_STATE:  o_rd_data <= {14'h0, soc, 12'h0,
                                                  ownership_request,
                                                  bulk_list_filled,
                                                  control_list_filled,
                                                  sr_state == SR_BUSY};
                    OFF_IRQ_STATUS: o_rd_data <= {30'h0, irq_status};
                    OFF_IRQ_MASK:   o_rd_data <= {30'h0, irq_mask};
                    default:        o_rd_data <= '0;
                endcase
            end
        end
    end

    ctrl_bulk_ratio_sched u_ratio (
        .i_sys_clk     (i_sys_clk),
        .i_rst         (i_rst),
        .i_clk_en      (i_clk_en),
        .i_frame_start (i_evt.frame_start),
        .i_clear       (sr_done),
        .i_ratio       (op.ctrl_bulk_ratio),
        .i_ctrl_done   (i_evt.ctrl_ed_done),
        .i_bulk_done   (i_evt.bulk_ed_done),
        .o_pick_bulk   (o_pick_bulk)
    );

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    chk_iso_skip: assert property (
        i_clk_en && i_evt.iso_ed_seen && !op.iso_enable
        |=> o_iso_valid && !o_iso_accept)
        else $error("iso descriptor accepted while disabled");

    chk_iso_start: assert property (
        i_clk_en && i_evt.iso_ed_seen && op.iso_enable && o_periodic_active
        |=> o_iso_accept)
        else $error("iso descriptor refused while enabled");

    chk_periodic_stop: assert property (
        i_clk_en && i_evt.frame_start && !op.periodic_list_enable
        |=> !o_periodic_active)
        else $error("periodic list still active next frame");

    chk_periodic_start: assert property (
        i_clk_en && i_evt.frame_start && op.periodic_list_enable && !sr_done
        |=> o_periodic_active)
        else $error("periodic list not started at frame");

    chk_periodic_hold: assert property (
        i_clk_en && !i_evt.frame_start && !sr_done
        |=> $stable(o_periodic_active))
        else $error("periodic gate moved inside a frame");

    chk_overrun_count: assert property (
        i_clk_en && i_evt.overrun && !sr_done
        |=> soc == 2'($past(soc) + 2'h1))
        else $error("overrun count not incremented");

    chk_overrun_wrap: assert property (
        i_clk_en && i_evt.overrun && !sr_done && soc == 2'h3
        |=> soc == 2'h0)
        else $error("overrun count did not wrap");

    chk_own_no_irq: assert property (
        i_clk_en && wr_cmd && i_wr_data[CMD_OWN_BIT] && !i_evt.overrun &&
        !sr_done && !wr_stat
        |=> ownership_request && irq_status == $past(irq_status))
        else $error("ownership request changed interrupt state");

    chk_bulk_gate: assert property (
        i_clk_en && i_evt.bulk_start_req && i_bulk_current_ptr == '0 &&
        !bulk_list_filled |=> !o_bulk_grant)
        else $error("bulk started on empty pointer without filled");

    chk_bulk_clear: assert property (
        i_clk_en && next_bulk_grant && bulk_list_filled && !sr_done &&
        !(wr_cmd && i_wr_data[CMD_BLF_BIT]) |=> !bulk_list_filled)
        else $error("bulk filled not cleared on start");

    chk_ctrl_gate: assert property (
        i_clk_en && i_evt.ctrl_start_req && i_control_head_ptr == '0 &&
        !control_list_filled |=> !o_ctrl_grant)
        else $error("control started on empty head without filled");

    chk_ctrl_clear: assert property (
        i_clk_en && next_ctrl_grant && control_list_filled && !sr_done &&
        !(wr_cmd && i_wr_data[CMD_CLF_BIT]) |=> !control_list_filled)
        else $error("control filled not cleared on start");

    chk_reset_zero: assert property (
        i_clk_en && sr_state == SR_IDLE && wr_cmd &&
        !i_wr_data[CMD_RESET_BIT] |=> sr_state == SR_IDLE)
        else $error("writing zero started a soft reset");

    chk_reset_bound: assert property (
        sr_done |=> !o_soft_reset_busy)
        else $error("soft reset busy did not clear when done");

    chk_fs_suspend: assert property (
        sr_done |=> op.functional_state == FS_SUSPEND && sr_state == SR_IDLE)
        else $error("soft reset did not end in suspend");

    chk_no_usb_reset: assert property (
        sr_done ##1 (i_clk_en && !wr_op) |=> !o_usb_reset_drive)
        else $error("soft reset drove usb reset");

    cov_soft_reset: cover property (sr_done ##1 !o_soft_reset_busy);
    cov_bulk_filled: cover property (
        i_bulk_current_ptr == '0 && bulk_list_filled && next_bulk_grant);
    cov_overrun_wrap: cover property (i_evt.overrun && soc == 2'h3);
    cov_iso_accept: cover property (o_iso_accept);

endmodule : usb_host_list_control_cmd

//--- core/usb_hc_list_pkg.sv
// constants, field layouts and carrier types of the list control block
// assumes one 250 MHz system clock shared by the bus and the list engine
package usb_hc_list_pkg;

    // register bus geometry
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          PTR_W           = 32;

    // register byte offsets
    localparam logic [7:0]  OFF_OP_MODE     = 8'h04;
    localparam logic [7:0]  OFF_CMD_STATE   = 8'h08;
    localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h0c;
    localparam logic [7:0]  OFF_IRQ_MASK    = 8'h10;

    // command_and_state field positions
    localparam int          CMD_RESET_BIT   = 0;
    localparam int          CMD_CLF_BIT     = 1;
    localparam int          CMD_BLF_BIT     = 2;
    localparam int          CMD_OWN_BIT     = 3;
    localparam int          CMD_SOC_LSB     = 16;
    localparam int          CMD_SOC_MSB     = 17;

    // interrupt status and mask layout
    localparam int          IRQ_W           = 2;
    localparam int          IRQ_OVERRUN_BIT = 0;
    localparam int          IRQ_RSTDONE_BIT = 1;

    // reset values
    localparam logic [7:0]        OP_MODE_RESET = 8'h00;
    localparam logic [1:0]        SOC_RESET     = 2'h0;
    localparam logic [IRQ_W-1:0]  IRQ_RESET     = 2'h0;

    // timing
    localparam int          CLK_PERIOD_NS      = 4;
    localparam int          SOFT_RESET_TIME_NS = 64;
    localparam int          SOFT_RESET_CYCLES  =
        (SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // functional state encodings
    typedef enum logic [1:0] {
        FS_RESET   = 2'b00,
        FS_RESUME  = 2'b01,
        FS_OPER    = 2'b10,
        FS_SUSPEND = 2'b11
    } func_state_t;

    // soft reset sequencer
    typedef enum logic {
        SR_IDLE = 1'b0,
        SR_BUSY = 1'b1
    } sr_state_t;

    // operating_mode bits 7..0
    typedef struct packed {
        func_state_t functional_state;
        logic        bulk_list_enable;
        logic        control_list_enable;
        logic        iso_enable;
        logic        periodic_list_enable;
        logic [1:0]  ctrl_bulk_ratio;
    } op_mode_t;

    // one-cycle events from the list walker
    typedef struct packed {
        logic frame_start;
        logic iso_ed_seen;
        logic overrun;
        logic ctrl_ed_done;
        logic bulk_ed_done;
        logic ctrl_start_req;
        logic bulk_start_req;
    } sched_evt_t;

endpackage : usb_hc_list_pkg

//--- core/ctrl_bulk_ratio_sched.sv
// control versus bulk turn keeper for one frame
// assumes done pulses come from the list walker on the same clock
`timescale 1ns/100ps
module ctrl_bulk_ratio_sched (
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic       i_clk_en,
    // control
    input  wire logic       i_frame_start,
    input  wire logic       i_clear,
    input  wire logic [1:0] i_ratio,
    input  wire logic       i_ctrl_done,
    input  wire logic       i_bulk_done,
    // turn
    output logic            o_pick_bulk
);
    import usb_hc_list_pkg::*;

    logic [1:0] ctrl_cnt;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_cnt    <= 2'h0;
            o_pick_bulk <= 1'b0;
        end else if (i_clk_en) begin
            if (i_frame_start || i_clear) begin
                ctrl_cnt    <= 2'h0;
                o_pick_bulk <= 1'b0;
            end else if (!o_pick_bulk && i_ctrl_done) begin
                if (ctrl_cnt >= i_ratio) begin
                    ctrl_cnt    <= 2'h0;
                    o_pick_bulk <= 1'b1;
                end else begin
                    ctrl_cnt <= ctrl_cnt + 2'h1;
                end
            end else if (o_pick_bulk && i_bulk_done) begin
                o_pick_bulk <= 1'b0;
            end
        end
    end

    chk_ratio_turn: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        i_clk_en && !i_frame_start && !i_clear && !o_pick_bulk &&
        i_ctrl_done && ctrl_cnt >= i_ratio |=> o_pick_bulk)
        else $error("bulk turn not given after ratio reached");

    chk_ratio_wait: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        i_clk_en && !i_frame_start && !i_clear && !o_pick_bulk &&
        i_ctrl_done && ctrl_cnt < i_ratio |=> !o_pick_bulk)
        else $error("bulk turn given too early");

    cov_bulk_turn: cover property (
        @(posedge i_sys_clk) disable iff (i_rst)
        i_ratio == 2'h3 && $rose(o_pick_bulk));

endmodule : ctrl_bulk_ratio_sched

//--- tb/tb.sv
// self-checking bench for the list control and command block
// assumes the block alone drives its register port and walker events
`timescale 1ns/100ps
`define CHK(g, e) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("unexpected at %0t got %h exp %h", $time, (g), (e)); \
    end \
end
module tb;
    import usb_hc_list_pkg::*;
    // short reset sequence keeps polling brief
    localparam int SR_CYC = 4;
    logic              i_sys_clk = 0;
    logic              i_rst     = 1;
    logic              en        = 1;
    logic              i_wr_en   = 0;
    logic              i_rd_en   = 0;
    logic [7:0]        i_addr    = '0;
    logic [31:0]       i_wr_data = '0;
    sched_evt_t        i_evt     = '0;
    logic [31:0]       bptr      = '0;
    logic [31:0]       cptr      = '0;
    logic [31:0]       o_rd_data;
    logic              pact, iso_v, iso_a, cgnt, bgnt, pick, busy, usbr;
    logic              o_irq;
    logic [31:0]       d;
    int                err_total, samples_checked, cycles, n;
    always #2 i_sys_clk = ~i_sys_clk;
    usb_host_list_control_cmd #(.SOFT_RESET_CYCLES(SR_CYC)) dut_u (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(en),
        .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_evt(i_evt),
        .i_bulk_current_ptr(bptr), .i_control_head_ptr(cptr),
        .o_periodic_active(pact), .o_iso_valid(iso_v),
        .o_iso_accept(iso_a), .o_ctrl_grant(cgnt), .o_bulk_grant(bgnt),
        .o_pick_bulk(pick), .o_soft_reset_busy(busy),
        .o_usb_reset_drive(usbr), .o_irq(o_irq));
    function automatic logic exp_grant(logic en, logic [31:0] p, logic f);
        return en & ((p != 32'h0) | f);
    endfunction : exp_grant
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_sys_clk);
        i_addr <= a; i_wr_data <= v; i_wr_en <= 1'b1;
        @(posedge i_sys_clk);
        i_wr_en <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge i_sys_clk);
        i_addr <= a; i_rd_en <= 1'b1;
        @(posedge i_sys_clk);
        i_rd_en <= 1'b0;
        #1 d = o_rd_data;
    endtask : rd
    // one-cycle walker pulse, bit 6 frame start down to bit 0 bulk request
    task automatic ev(input int b);
        @(posedge i_sys_clk);
        i_evt <= sched_evt_t'(7'h1 << b);
        @(posedge i_sys_clk);
        i_evt <= '0;
        #1;
    endtask : ev
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // budget well above the fewer than 200 cycles the tests need
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(67807));
        repeat (20) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        wr(OFF_OP_MODE, 32'h84);
        `CHK(pact, 1'b0)
        ev(6); `CHK(pact, 1'b1)
        ev(5); `CHK({iso_v, iso_a}, 2'b10)
        wr(OFF_OP_MODE, 32'h88);
        ev(5); `CHK({iso_v, iso_a}, 2'b11)
        `CHK(pact, 1'b1)
        ev(6); `CHK(pact, 1'b0)
        $display("test gating done");
        for (int r = 0; r < 4; r++) begin
            wr(OFF_OP_MODE, 32'hb0 | r);
            ev(6);
            repeat (r) begin
                ev(3); `CHK(pick, 1'b0)
            end
            ev(3); `CHK(pick, 1'b1)
            ev(2); `CHK(pick, 1'b0)
        end
        $display("test ratio done");
        // filled handshake, k=0 bulk k=1 ctrl
        for (int k = 0; k < 2; k++) begin
            bptr <= '0; cptr <= '0;
            ev(k); `CHK(k ? cgnt : bgnt, exp_grant(1'b1, 0, 1'b0))
            wr(OFF_CMD_STATE, 32'h4 >> k);
            ev(k); `CHK(k ? cgnt : bgnt, exp_grant(1'b1, 0, 1'b1))
            rd(OFF_CMD_STATE); `CHK(d[2-k], 1'b0)
            bptr <= $urandom | 32'h10; cptr <= $urandom | 32'h10;
            ev(k); `CHK(k ? cgnt : bgnt, exp_grant(1'b1, bptr | cptr, 1'b0))
        end
        $display("test filled done");
        // count and wrap, masked then unmasked irq
        wr(OFF_IRQ_MASK, 32'h0);
        for (int i = 1; i <= 5; i++) begin
            ev(4); rd(OFF_CMD_STATE); `CHK(d[17:16], 2'(i))
            if (i == 1) begin
                `CHK(o_irq, 1'b0)
                wr(OFF_IRQ_MASK, 32'h1);
            end
        end
        `CHK(o_irq, 1'b1)
        wr(OFF_IRQ_STATUS, 32'h1);
        wr(OFF_CMD_STATE, 32'h8);
        rd(OFF_CMD_STATE); `CHK(d[3], 1'b1)
        `CHK(o_irq, 1'b0)
        $display("test overrun done");
        wr(OFF_CMD_STATE, 32'h0);
        rd(OFF_CMD_STATE); `CHK(d[3:0], 4'h8)
        wr(OFF_CMD_STATE, 32'h1);
        // busy line follows the write edge by one cycle
        @(posedge i_sys_clk);
        #1 `CHK(busy, 1'b1)
        n = 0;
        do begin
            rd(OFF_CMD_STATE);
            `CHK(usbr, 1'b0)
            n++;
        end while (d[0] === 1'b1 && n < 20);
        `CHK(d, 32'h0)
        `CHK(n > 1, 1'b1)
        `CHK(usbr, 1'b0)
        rd(OFF_OP_MODE); `CHK(d, 32'hc0)
        // clock enable low freezes the overrun count
        @(posedge i_sys_clk);
        en <= 1'b0;
        ev(4);
        @(posedge i_sys_clk);
        en <= 1'b1;
        rd(OFF_CMD_STATE); `CHK(d[17:16], 2'h0)
        $display("test soft reset done");
        give_verdict();
    end
endmodule : tb
